// ### homing_defs.vh
`ifndef HOMING_DEFS_VH
`define HOMING_DEFS_VH

// homing method selector codes handled here
`define HM_M20        8'h14
`define HM_M21        8'h15
`define HM_M22        8'h16
`define HM_M23        8'h17
`define HM_M24        8'h18
`define HM_M25        8'h19
`define HM_M26        8'h1a
`define HM_M27        8'h1b

// direction and speed class encodings
`define DIR_POS       1'b1
`define DIR_NEG       1'b0
`define SPD_HIGH      1'b1
`define SPD_LOW       1'b0

// segment table word layout
`define TBL_W         8
`define TBL_NSEG_HI   7
`define TBL_NSEG_LO   6
`define TBL_DIR0      5
`define TBL_SPD0      4
`define TBL_DIR1      3
`define TBL_SPD1      2
`define TBL_DIR2      1
`define TBL_SPD2      0
`define TBL_NONE      8'h00

// segment counts and indices
`define NSEG_NONE     2'h0
`define NSEG_ONE      2'h1
`define NSEG_TWO      2'h2
`define NSEG_THREE    2'h3
`define SEG_FIRST     2'h0
`define SEG_SECOND    2'h1
`define SEG_THIRD     2'h2
`define SEG_STEP      2'h1

// switch bit positions in the synchroniser bundle
`define SW_HOME       0
`define SW_LIM_POS    1
`define SW_LIM_NEG    2
`define SW_COUNT      3
`define SW_RESET      3'h0

// sequencer state codes
`define ST_W          3
`define ST_IDLE       3'h0
`define ST_RUN        3'h1
`define ST_DONE       3'h2
`define ST_FAULT      3'h3

`endif

// ### switch_edge_sync.v
`include "homing_defs.vh"

module switch_edge_sync #(
  parameter WIDTH = `SW_COUNT
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] sw_in,
  output reg  [WIDTH-1:0] sw_level,
  output wire [WIDTH-1:0] sw_rise,
  output wire [WIDTH-1:0] sw_fall
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] prev_r;

  // meta_r feeds only sw_level; edges compare the two later stages
  always @(posedge clk) begin
    if (!rstn) begin
      meta_r   <= {WIDTH{1'b0}};
      sw_level <= {WIDTH{1'b0}};
      prev_r   <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= sw_in;
      sw_level <= meta_r;
      prev_r   <= sw_level;
    end
  end

  assign sw_rise = sw_level & ~prev_r;
  assign sw_fall = ~sw_level & prev_r;

endmodule

// ### home_switch_homing_sequencer.v
// Operation
// - methods 20..27: home switch is both home reference and slow-down point
// - method 20, switch off at start: positive low, stop on rising edge
// - method 20, switch on: negative high, falling reverses positive low, rising stops
// - method 21, switch off: negative high, rising reverses positive low, falling stops
// - methods 21,26,27, switch on: positive low at once, stop on falling edge
// - method 22, switch off: negative low at once, stop on rising edge
// - method 22, switch on: positive high, falling reverses negative low, rising stops
// - method 23, switch off: positive high, rising reverses negative low, falling stops
// - high search begun with switch off reverses at limit, keeping high speed
// - method 23 after limit reversal: rising slows negative low, falling stops
// - method 23, switch on: negative low at once, stop on falling edge
// - method 24, off: positive high, rising negative low, falling positive low, rising stops
// - method 24 after limit: rising negative low, falling positive low, rising stops
// - method 24, on: negative low, falling positive low, rising stops
// - method 25, off: positive high, rising positive low, falling negative low, rising stops
// - method 25 after limit: rising positive low, falling negative low, rising stops
// - method 25, on: positive low, falling negative low, rising stops
// - method 26, off: positive high, rising slows positive low, falling stops
// - method 26 after limit: rising switches to positive low, falling stops
// - method 27, off: negative high, rising reverses positive low, falling stops
// - method 27 after limit: rising slows positive low, falling stops
`include "homing_defs.vh"

module home_switch_homing_sequencer (
  input  wire       clk,
  input  wire       rstn,
  input  wire       start_req,
  input  wire       abort_req,
  input  wire [7:0] homing_method_select,
  input  wire       home_switch_input,
  input  wire       limit_pos_in,
  input  wire       limit_neg_in,
  output reg        move_en_r,
  output reg        dir_pos_r,
  output reg        speed_high_r,
  output reg        zero_speed_r,
  output reg        busy_r,
  output reg        home_done_r,
  output reg        home_fault_r,
  output reg        limit_reversed_r,
  output reg  [1:0] segment_r
);

  wire [`SW_COUNT-1:0] sw_level;
  wire [`SW_COUNT-1:0] sw_rise;
  wire [`SW_COUNT-1:0] sw_fall;

  switch_edge_sync #(
    .WIDTH (`SW_COUNT)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .sw_in    ({limit_neg_in, limit_pos_in, home_switch_input}),
    .sw_level (sw_level),
    .sw_rise  (sw_rise),
    .sw_fall  (sw_fall)
  );

  function [`TBL_W-1:0] pack;
    input [1:0] n;
    input       d0;
    input       s0;
    input       d1;
    input       s1;
    input       d2;
    input       s2;
    begin
      pack = {n, d0, s0, d1, s1, d2, s2};
    end
  endfunction

  // motion plan per method and start level; each segment ends on the next
  // home switch edge, so edge polarity alternates and need not be stored
  function [`TBL_W-1:0] plan;
    input [7:0] m;
    input       act;
    begin
      case (m)
        `HM_M20: begin
          if (!act)
            plan = pack(`NSEG_ONE, `DIR_POS, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_TWO, `DIR_NEG, `SPD_HIGH,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M21: begin
          if (!act)
            plan = pack(`NSEG_TWO, `DIR_NEG, `SPD_HIGH,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_ONE, `DIR_POS, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M22: begin
          if (!act)
            plan = pack(`NSEG_ONE, `DIR_NEG, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_TWO, `DIR_POS, `SPD_HIGH,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M23: begin
          // limit reversal keeps the same second segment
          if (!act)
            plan = pack(`NSEG_TWO, `DIR_POS, `SPD_HIGH,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_ONE, `DIR_NEG, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M24: begin
          if (!act)
            plan = pack(`NSEG_THREE, `DIR_POS, `SPD_HIGH,
                        `DIR_NEG, `SPD_LOW, `DIR_POS, `SPD_LOW);
          else
            plan = pack(`NSEG_TWO, `DIR_NEG, `SPD_LOW,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M25: begin
          if (!act)
            plan = pack(`NSEG_THREE, `DIR_POS, `SPD_HIGH,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_TWO, `DIR_POS, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M26: begin
          if (!act)
            plan = pack(`NSEG_TWO, `DIR_POS, `SPD_HIGH,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_ONE, `DIR_POS, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        `HM_M27: begin
          if (!act)
            plan = pack(`NSEG_TWO, `DIR_NEG, `SPD_HIGH,
                        `DIR_POS, `SPD_LOW, `DIR_NEG, `SPD_LOW);
          else
            plan = pack(`NSEG_ONE, `DIR_POS, `SPD_LOW,
                        `DIR_NEG, `SPD_LOW, `DIR_NEG, `SPD_LOW);
        end
        default: plan = `TBL_NONE;
      endcase
    end
  endfunction

  function seg_dir;
    input [`TBL_W-1:0] t;
    input [1:0]        s;
    begin
      case (s)
        `SEG_FIRST:  seg_dir = t[`TBL_DIR0];
        `SEG_SECOND: seg_dir = t[`TBL_DIR1];
        default:     seg_dir = t[`TBL_DIR2];
      endcase
    end
  endfunction

  function seg_spd;
    input [`TBL_W-1:0] t;
    input [1:0]        s;
    begin
      case (s)
        `SEG_FIRST:  seg_spd = t[`TBL_SPD0];
        `SEG_SECOND: seg_spd = t[`TBL_SPD1];
        default:     seg_spd = t[`TBL_SPD2];
      endcase
    end
  endfunction

  function [1:0] seg_count;
    input [`TBL_W-1:0] t;
    begin
      seg_count = t[`TBL_NSEG_HI:`TBL_NSEG_LO];
    end
  endfunction

  function [1:0] seg_after;
    input [1:0] s;
    begin
      seg_after = s + `SEG_STEP;
    end
  endfunction

  // segments alternate edges: even segments wait for rising when the
  // switch was off at start, for falling when it was on
  function edge_hit;
    input [1:0] s;
    input       act;
    input       rise;
    input       fall;
    begin
      if (s[0] ^ ~act)
        edge_hit = rise;
      else
        edge_hit = fall;
    end
  endfunction

  function limit_hit;
    input d;
    input lp;
    input ln;
    begin
      if (d == `DIR_POS)
        limit_hit = lp;
      else
        limit_hit = ln;
    end
  endfunction

  localparam [`ST_W-1:0] S_IDLE  = `ST_IDLE;
  localparam [`ST_W-1:0] S_RUN   = `ST_RUN;
  localparam [`ST_W-1:0] S_DONE  = `ST_DONE;
  localparam [`ST_W-1:0] S_FAULT = `ST_FAULT;

  reg [`ST_W-1:0]  state_r;
  reg [`ST_W-1:0]  state_nxt;
  reg [`TBL_W-1:0] plan_r;
  reg [`TBL_W-1:0] plan_nxt;
  reg              start_act_r;
  reg              start_act_nxt;
  reg [1:0]        seg_nxt;
  reg              rev_nxt;
  reg              dir_nxt;
  reg              spd_nxt;
  reg              move_nxt;
  reg              done_nxt;
  reg              fault_nxt;

  wire [`TBL_W-1:0] new_plan = plan(homing_method_select, sw_level[`SW_HOME]);
  wire [1:0]        nseg     = seg_count(plan_r);
  wire [1:0]        seg_next = seg_after(segment_r);
  wire              last_seg = (segment_r == nseg - `SEG_STEP);

  wire hs_edge   = edge_hit(segment_r, start_act_r,
                            sw_rise[`SW_HOME], sw_fall[`SW_HOME]);

  wire lim_ahead = limit_hit(dir_pos_r, sw_level[`SW_LIM_POS], sw_level[`SW_LIM_NEG]);

  // only the opening high-speed search of an off-at-start run may reverse
  wire may_rev = ~start_act_r & ~limit_reversed_r & speed_high_r &
                 (segment_r == `SEG_FIRST);

  always @* begin
    state_nxt     = state_r;
    plan_nxt      = plan_r;
    start_act_nxt = start_act_r;
    seg_nxt       = segment_r;
    rev_nxt       = limit_reversed_r;
    dir_nxt       = dir_pos_r;
    spd_nxt       = speed_high_r;
    move_nxt      = move_en_r;
    done_nxt      = home_done_r;
    fault_nxt     = home_fault_r;
    case (state_r)
      S_IDLE, S_DONE, S_FAULT: begin
        // done and fault hold until a new start, so software can poll them
        if (start_req) begin
          done_nxt  = 1'b0;
          fault_nxt = 1'b0;
          rev_nxt   = 1'b0;
          seg_nxt   = `SEG_FIRST;
          if (seg_count(new_plan) == `NSEG_NONE) begin
            state_nxt = S_FAULT;
            fault_nxt = 1'b1;
            move_nxt  = 1'b0;
          end else begin
            state_nxt     = S_RUN;
            plan_nxt      = new_plan;
            start_act_nxt = sw_level[`SW_HOME];
            dir_nxt       = seg_dir(new_plan, `SEG_FIRST);
            spd_nxt       = seg_spd(new_plan, `SEG_FIRST);
            move_nxt      = 1'b1;
          end
        end
      end
      S_RUN: begin
        if (abort_req) begin
          state_nxt = S_IDLE;
          move_nxt  = 1'b0;
          spd_nxt   = `SPD_LOW;
        end else if (hs_edge) begin
          if (last_seg) begin
            state_nxt = S_DONE;
            move_nxt  = 1'b0;
            spd_nxt   = `SPD_LOW;
            done_nxt  = 1'b1;
          end else begin
            seg_nxt = seg_next;
            dir_nxt = seg_dir(plan_r, seg_next);
            spd_nxt = seg_spd(plan_r, seg_next);
          end
        end else if (lim_ahead) begin
          if (may_rev) begin
            dir_nxt = ~dir_pos_r;
            rev_nxt = 1'b1;
          end else begin
            // any limit that may_rev does not allow means no home switch on this axis
            state_nxt = S_FAULT;
            move_nxt  = 1'b0;
            spd_nxt   = `SPD_LOW;
            fault_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
        move_nxt  = 1'b0;
        spd_nxt   = `SPD_LOW;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      state_r          <= S_IDLE;
      plan_r           <= `TBL_NONE;
      start_act_r      <= 1'b0;
      segment_r        <= `SEG_FIRST;
      limit_reversed_r <= 1'b0;
      dir_pos_r        <= `DIR_NEG;
      speed_high_r     <= `SPD_LOW;
      move_en_r        <= 1'b0;
      zero_speed_r     <= 1'b1;
      busy_r           <= 1'b0;
      home_done_r      <= 1'b0;
      home_fault_r     <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      plan_r           <= plan_nxt;
      start_act_r      <= start_act_nxt;
      segment_r        <= seg_nxt;
      limit_reversed_r <= rev_nxt;
      dir_pos_r        <= dir_nxt;
      speed_high_r     <= spd_nxt;
      move_en_r        <= move_nxt;
      zero_speed_r     <= ~move_nxt;
      busy_r           <= (state_nxt == S_RUN);
      home_done_r      <= done_nxt;
      home_fault_r     <= fault_nxt;
    end
  end

endmodule

// ### homing_monitor.sv
`include "homing_defs.vh"

module homing_monitor (
  input logic       clk,
  input logic       rstn,
  input logic       start_req,
  input logic [7:0] homing_method_select,
  input logic       home_switch_input,
  input logic       limit_pos_in,
  input logic       limit_neg_in,
  input logic       move_en_r,
  input logic       dir_pos_r,
  input logic       speed_high_r,
  input logic       zero_speed_r,
  input logic       busy_r,
  input logic       home_done_r,
  input logic       home_fault_r,
  input logic       limit_reversed_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_zero_speed_flag: assert property (zero_speed_r == !move_en_r)
    else $error("zero speed flag disagrees with motion");
  a_valid_start_moves: assert property (start_req && !busy_r && homing_method_select >= `HM_M20 && homing_method_select <= `HM_M27 |=> busy_r && move_en_r && !home_fault_r)
    else $error("valid start did not begin motion");
  a_bad_method_fault: assert property (start_req && !busy_r && (homing_method_select < `HM_M20 || homing_method_select > `HM_M27) |=> home_fault_r && !move_en_r)
    else $error("unknown method did not fault");
  a_idle_stays_idle: assert property (!busy_r && !start_req |=> !move_en_r && !busy_r)
    else $error("motion without a start request");
  a_done_halts_motion: assert property ($rose(home_done_r) |-> !move_en_r && !busy_r && !speed_high_r && zero_speed_r)
    else $error("completion while still moving");
  // latency slack of one cycle shorter than the two-stage sampler path, none longer
  a_done_on_edge: assert property ($rose(home_done_r) |-> $past(home_switch_input, 2) != $past(home_switch_input, 3) || $past(home_switch_input, 3) != $past(home_switch_input, 4))
    else $error("completion without a home switch edge");
  a_segment_on_edge: assert property (busy_r && $past(busy_r) && $changed({dir_pos_r, speed_high_r}) && $stable(limit_reversed_r) |-> $past(home_switch_input, 2) != $past(home_switch_input, 3) || $past(home_switch_input, 3) != $past(home_switch_input, 4))
    else $error("segment change without a home switch edge");
  a_limit_keeps_high: assert property ($rose(limit_reversed_r) |-> move_en_r && speed_high_r && dir_pos_r != $past(dir_pos_r))
    else $error("limit reversal lost speed or direction");
  a_limit_cause: assert property ($rose(limit_reversed_r) |-> ($past(limit_pos_in, 3) && !dir_pos_r) || ($past(limit_neg_in, 3) && dir_pos_r))
    else $error("reversal without a limit in travel direction");
  a_done_not_busy: assert property (home_done_r |-> !busy_r)
    else $error("complete flag while running");
endmodule

bind home_switch_homing_sequencer homing_monitor homing_monitor_i (.clk(clk), .rstn(rstn),
  .start_req(start_req), .homing_method_select(homing_method_select),
  .home_switch_input(home_switch_input), .limit_pos_in(limit_pos_in),
  .limit_neg_in(limit_neg_in), .move_en_r(move_en_r), .dir_pos_r(dir_pos_r),
  .speed_high_r(speed_high_r), .zero_speed_r(zero_speed_r), .busy_r(busy_r),
  .home_done_r(home_done_r), .home_fault_r(home_fault_r),
  .limit_reversed_r(limit_reversed_r));

// ### axis_model.sv
module axis_model #(
  parameter int HOME_LO = 100,
  parameter int HOME_HI = 139,
  parameter int LIM_P   = 400,
  parameter int LIM_N   = -300,
  parameter int HI_STEP = 4,
  parameter int LO_STEP = 1
) (
  input  logic clk,
  input  logic move_en,
  input  logic dir_pos,
  input  logic speed_high,
  output logic home_sw,
  output logic lim_pos,
  output logic lim_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  // switch span is wider than the overshoot of a three-cycle reaction
  int pos = 0;

  always @(posedge clk) begin
    if (move_en) begin
      pos <= dir_pos ? pos + (speed_high ? HI_STEP : LO_STEP)
                     : pos - (speed_high ? HI_STEP : LO_STEP);
    end
  end

  assign home_sw = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign lim_pos = pos >= LIM_P;
  assign lim_neg = pos <= LIM_N;
endmodule

// ### home_switch_homing_sequencer_tb.sv
`include "homing_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module home_switch_homing_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [7:0] m; int p; int n; logic [7:0] tr; logic rv; logic hs; } row_t;
  logic       clk, rstn, start_req, abort_req;
  logic [7:0] homing_method_select;
  logic [7:0] tr;
  wire        home_switch_input, limit_pos_in, limit_neg_in;
  wire        move_en_r, dir_pos_r, speed_high_r, zero_speed_r, busy_r;
  wire        home_done_r, home_fault_r, limit_reversed_r;
  wire  [1:0] segment_r;
  int         err_total, num_checks, seg_n;
  row_t       rows[21];

  home_switch_homing_sequencer home_switch_homing_sequencer_i (.clk(clk), .rstn(rstn),
    .start_req(start_req), .abort_req(abort_req), .homing_method_select(homing_method_select),
    .home_switch_input(home_switch_input), .limit_pos_in(limit_pos_in),
    .limit_neg_in(limit_neg_in), .move_en_r(move_en_r), .dir_pos_r(dir_pos_r),
    .speed_high_r(speed_high_r), .zero_speed_r(zero_speed_r), .busy_r(busy_r),
    .home_done_r(home_done_r), .home_fault_r(home_fault_r),
    .limit_reversed_r(limit_reversed_r), .segment_r(segment_r));
  axis_model axis_model_i (.clk(clk), .move_en(move_en_r), .dir_pos(dir_pos_r),
    .speed_high(speed_high_r), .home_sw(home_switch_input), .lim_pos(limit_pos_in),
    .lim_neg(limit_neg_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // trace of {dir, speed} segments, two bits each, oldest highest
  always @(negedge clk) begin
    if (move_en_r === 1'b1 && (seg_n == 0 || {dir_pos_r, speed_high_r} !== tr[1:0])) begin
      tr <= {tr[5:0], dir_pos_r, speed_high_r};
      seg_n <= seg_n + 1;
    end
  end

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic go(input logic [7:0] m, input int p);
    @(negedge clk);
    axis_model_i.pos = p;
    tr = 8'h00;
    seg_n = 0;
    repeat (4) @(negedge clk);
    homing_method_select = m;
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
  endtask

  task automatic run(input logic [7:0] m, input int p);
    int k;
    k = 0;
    go(m, p);
    while (home_done_r !== 1'b1 && home_fault_r !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
  endtask

  initial begin
    #200000;
    err_total++;
    $display("BAD watchdog exp done got hang");
    tally_and_finish;
  end

  initial begin
    // p: 0 below switch, 120 on it, 250 above; limits sit further out
    rows = '{
      '{`HM_M20, 0, 1, 8'h02, 0, 1},
      '{`HM_M20, 120, 2, 8'h06, 0, 1},
      '{`HM_M21, 250, 2, 8'h06, 0, 0},
      '{`HM_M21, 120, 1, 8'h02, 0, 0},
      '{`HM_M22, 250, 1, 8'h00, 0, 1},
      '{`HM_M22, 120, 2, 8'h0c, 0, 1},
      '{`HM_M23, 0, 2, 8'h0c, 0, 0},
      '{`HM_M23, 250, 3, 8'h34, 1, 0},
      '{`HM_M23, 120, 1, 8'h00, 0, 0},
      '{`HM_M24, 0, 3, 8'h32, 0, 1},
      '{`HM_M24, 250, 4, 8'hd2, 1, 1},
      '{`HM_M24, 120, 2, 8'h02, 0, 1},
      '{`HM_M25, 0, 3, 8'h38, 0, 1},
      '{`HM_M25, 250, 4, 8'hd8, 1, 1},
      '{`HM_M25, 120, 2, 8'h08, 0, 1},
      '{`HM_M26, 0, 2, 8'h0e, 0, 0},
      '{`HM_M26, 250, 3, 8'h36, 1, 0},
      '{`HM_M26, 120, 1, 8'h02, 0, 0},
      '{`HM_M27, 250, 2, 8'h06, 0, 0},
      '{`HM_M27, 0, 3, 8'h1e, 1, 0},
      '{`HM_M27, 120, 1, 8'h02, 0, 0}
    };
    rstn = 1'b0;
    start_req = 1'b0;
    abort_req = 1'b0;
    homing_method_select = `HM_M20;
    repeat (16) @(negedge clk);
    `CHK("reset_outs", 5'b00010, {move_en_r, busy_r, home_done_r, zero_speed_r, home_fault_r})
    rstn = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].m, rows[i].p);
      `CHK("done_fault", 2'b10, {home_done_r, home_fault_r})
      `CHK("trace", rows[i].tr, tr)
      `CHK("segments", rows[i].n, seg_n)
      `CHK("reversed", rows[i].rv, limit_reversed_r)
      `CHK("seg_index", rows[i].n - rows[i].rv - 1, segment_r)
      `CHK("stop_edge", rows[i].hs, home_switch_input)
    end
    // code just below the handled range
    go(8'h13, 0);
    `CHK("bad_low", 2'b01, {move_en_r, home_fault_r})
    // abort mid-search, then switch edges while idle must not move
    go(`HM_M23, 0);
    repeat (10) @(negedge clk);
    abort_req = 1'b1;
    @(negedge clk);
    abort_req = 1'b0;
    `CHK("abort", 5'b00001, {move_en_r, busy_r, home_done_r, home_fault_r, zero_speed_r})
    axis_model_i.pos = 120;
    repeat (6) @(negedge clk);
    axis_model_i.pos = 0;
    repeat (6) @(negedge clk);
    `CHK("idle_hold", 2'b00, {move_en_r, busy_r})
    // fault is clear here, so only this start can raise it
    go(8'h1c, 0);
    `CHK("bad_high", 2'b01, {move_en_r, home_fault_r})
    // reset during a run
    go(`HM_M22, 250);
    repeat (5) @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("mid_reset", 5'b00010, {move_en_r, busy_r, home_done_r, zero_speed_r, home_fault_r})
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    run(`HM_M21, 120);
    `CHK("post_reset", 2'b10, {home_done_r, home_fault_r})
    tally_and_finish;
  end
endmodule
